// *** rtl/nibble_port_regs.vh ***
/*
 * Register offsets, field positions and reset values for the nibble port.
 * Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
 */
`ifndef NIBBLE_PORT_REGS_VH
`define NIBBLE_PORT_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PORT_DATA     8'h00
`define OFS_PORT_MODE     8'h04
`define OFS_PORT_CONFIG   8'h08
`define OFS_CMP_MODE      8'h0c
`define OFS_IRQ_REQUEST   8'h10
`define OFS_CMP_STATUS    8'h14
`define OFS_TIMER_SRC     8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_DIR_LOW       0
`define BIT_DIR_HIGH      1
`define BIT_OPEN_DRAIN    2
`define BIT_CMP_ENABLE    1
`define BIT_FLAG_A        0
`define BIT_FLAG_B        1
`define BIT_EDGE_LO       6
`define BIT_EDGE_HI       7
`define BIT_SRC_SEL       0
`define BIT_SRC_IDX_LO    1
`define BIT_SRC_IDX_HI    3

// ----------------------------------------------------------------
// Edge selection codes
// ----------------------------------------------------------------
`define EDGE_RISING       2'h0
`define EDGE_FALLING      2'h1
`define EDGE_BOTH         2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PORT_DATA     8'h00
`define RST_PORT_MODE     2'h3
`define RST_OPEN_DRAIN    1'h0
`define RST_CMP_ENABLE    1'h0
`define RST_EDGE_MODE     2'h0
`define RST_TIMER_SRC     4'h0

`endif

// *** rtl/pin_sync.v ***
/*
 * Two-flop synchroniser for a bus of pin levels.
 * Assumes the inputs change no faster than the clock can sample them.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta_reg;

    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b0}};
            q        <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// *** rtl/edge_detect.v ***
/*
 * Edge detector with rising, falling or both-edge selection.
 * Assumes a level already synchronised to clk.
 */
`timescale 1ns/1ps
`include "nibble_port_regs.vh"

module edge_detect (
    input  wire       clk,
    input  wire       rst,
    input  wire       level,
    input  wire [1:0] mode,
    output reg        hit
);

    reg last_reg;

    always @(posedge clk) begin
        if (rst)
            last_reg <= 1'b0;
        else
            last_reg <= level;
    end

    always @* begin
        case (mode)
            `EDGE_RISING:  hit = level & ~last_reg;
            `EDGE_FALLING: hit = ~level & last_reg;
            default:       hit = level ^ last_reg;
        endcase
    end

endmodule

// *** rtl/nibble_port_with_comparator_inputs.v ***
/*
 * Eight-line nibble-direction port with two comparator-backed inputs,
 * edge-triggered request flags and timer edge source routing.
 * Assumes a classic Wishbone master, pins synchronous to clk, and an
 * external analog front end that delivers the comparator results as
 * digital levels.
 */
`timescale 1ns/1ps
`include "nibble_port_regs.vh"

// Behaviour
// RULE1: Eight port lines, each usable as input or output.
// RULE2: Direction is set per nibble; four lines share one setting.
// RULE3: Open-drain select bit picks push-pull or open-drain drive.
// RULE4: Software programs a nibble's direction before using it as I/O.
// RULE5: Hardware reset makes all eight lines inputs, drivers off.
// RULE6: Pull-up option per nibble, given as a parameter.
// RULE7: Pull-up is off on any line programmed as output.
// RULE8: Stop mode recovery returns both nibbles to input.
// RULE9: Comparator results replace the two inputs when enabled.
// RULE10: Bit 1 of comparator mode register enables comparator inputs.
// RULE11: Both inputs flag rising, falling or both edges per bits 7:6.
// RULE12: Timer edge source is comparator input a or a port 2 line.
// RULE13: Inputs read synchronised pins; outputs read the output latch.
module nibble_port_with_comparator_inputs #(
    parameter PULLUP_LOW  = 1'b0,
    parameter PULLUP_HIGH = 1'b0
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [7:0]  port_in,
    output reg  [7:0]  port_out,
    output reg  [7:0]  port_oe,
    output reg  [7:0]  pullup_en,
    input  wire        stop_mode_recovery,
    input  wire        comparator_input_a,
    input  wire        comparator_input_b,
    input  wire        comparator_result_a,
    input  wire        comparator_result_b,
    input  wire [7:0]  port2_in,
    output reg         irq_request_a,
    output reg         irq_request_b,
    output reg         timer_edge_in
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Expands the two nibble direction bits to eight lines, 1 = output
    function [7:0] out_lines;
        input [1:0] mode;
        begin
            out_lines = {{4{~mode[`BIT_DIR_HIGH]}}, {4{~mode[`BIT_DIR_LOW]}}};
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg  [7:0] latch_reg;
    reg  [7:0] latch_next;
    reg  [1:0] mode_reg;
    reg  [1:0] mode_next;
    reg        open_drain_select_bit_reg;
    reg        open_drain_select_bit_next;
    reg        cmp_enable_reg;
    reg        cmp_enable_next;
    reg  [1:0] edge_mode_reg;
    reg  [1:0] edge_mode_next;
    reg        flag_a_reg;
    reg        flag_a_next;
    reg        flag_b_reg;
    reg        flag_b_next;
    reg  [3:0] timer_src_reg;
    reg  [3:0] timer_src_next;
    reg  [31:0] rd_data;

    wire [7:0] port_sync;
    wire [7:0] port2_sync;
    wire [3:0] cmp_sync;
    wire       cmp_value_a;
    wire       cmp_value_b;
    wire       edge_a;
    wire       edge_b;
    wire       bus_req;
    wire       bus_wr;
    wire       lane0;
    wire       clr_a;
    wire       clr_b;
    wire [7:0] drive_out;
    wire [7:0] port_readback;
    wire [7:0] pullup_option;
    wire       timer_src_next_level;
    wire       irq_hit;
    wire [7:0] drive_next;
    wire [7:0] enable_next;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    pin_sync #(
        .WIDTH (8)
    ) u_port_sync (
        .clk (clk),
        .rst (rst),
        .d   (port_in),
        .q   (port_sync)
    );

    pin_sync #(
        .WIDTH (8)
    ) u_port2_sync (
        .clk (clk),
        .rst (rst),
        .d   (port2_in),
        .q   (port2_sync)
    );

    pin_sync #(
        .WIDTH (4)
    ) u_cmp_sync (
        .clk (clk),
        .rst (rst),
        .d   ({comparator_result_b, comparator_result_a,
               comparator_input_b, comparator_input_a}),
        .q   (cmp_sync)
    );

    // ----------------------------------------------------------------
    // Comparator-backed inputs
    // ----------------------------------------------------------------
    // Comparator outputs stand in for the pin levels when enabled
    assign cmp_value_a = cmp_enable_reg ? cmp_sync[2] : cmp_sync[0]; // see RULE9 see RULE10
    assign cmp_value_b = cmp_enable_reg ? cmp_sync[3] : cmp_sync[1]; // see RULE9 see RULE10

    edge_detect u_edge_a (
        .clk   (clk),
        .rst   (rst),
        .level (cmp_value_a),
        .mode  (edge_mode_reg),
        .hit   (edge_a)
    );

    edge_detect u_edge_b (
        .clk   (clk),
        .rst   (rst),
        .level (cmp_value_b),
        .mode  (edge_mode_reg),
        .hit   (edge_b)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i;
    assign lane0   = wb_sel_i[0];
    assign irq_hit = bus_wr & lane0 & (wb_adr_i == `OFS_IRQ_REQUEST);
    assign clr_a   = irq_hit & wb_dat_i[`BIT_FLAG_A];
    assign clr_b   = irq_hit & wb_dat_i[`BIT_FLAG_B];

    // ----------------------------------------------------------------
    // Pin drive and readback
    // ----------------------------------------------------------------
    assign drive_out = out_lines(mode_reg);

    // Input lines show the pin, output lines show the latch
    assign port_readback = (drive_out & latch_reg) | (~drive_out & port_sync); // see RULE13

    assign pullup_option = {{4{PULLUP_HIGH[0]}}, {4{PULLUP_LOW[0]}}}; // see RULE6

    assign timer_src_next_level = timer_src_reg[`BIT_SRC_SEL] ?
                                  port2_sync[timer_src_reg[`BIT_SRC_IDX_HI:`BIT_SRC_IDX_LO]] :
                                  cmp_value_a; // see RULE12

    // ----------------------------------------------------------------
    // Next pin drive
    // ----------------------------------------------------------------
    // Drive pattern that the next edge applies to the pins
    assign drive_next  = out_lines(mode_next);
    assign enable_next = drive_next &
                         (open_drain_select_bit_next ? 8'hff : ~latch_next); // see RULE3

    // ----------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------
    always @* begin
        latch_next                 = latch_reg;
        mode_next                  = mode_reg;
        open_drain_select_bit_next = open_drain_select_bit_reg;
        cmp_enable_next            = cmp_enable_reg;
        edge_mode_next             = edge_mode_reg;
        timer_src_next             = timer_src_reg;
        if (bus_wr && lane0) begin
            case (wb_adr_i)
                `OFS_PORT_DATA: begin
                    latch_next = wb_dat_i[7:0];
                end
                `OFS_PORT_MODE: begin
                    mode_next = wb_dat_i[`BIT_DIR_HIGH:`BIT_DIR_LOW]; // see RULE2 see RULE4
                end
                `OFS_PORT_CONFIG: begin
                    open_drain_select_bit_next = wb_dat_i[`BIT_OPEN_DRAIN]; // see RULE3
                end
                `OFS_CMP_MODE: begin
                    cmp_enable_next = wb_dat_i[`BIT_CMP_ENABLE]; // see RULE10
                end
                `OFS_IRQ_REQUEST: begin
                    edge_mode_next = wb_dat_i[`BIT_EDGE_HI:`BIT_EDGE_LO]; // see RULE11
                end
                `OFS_TIMER_SRC: begin
                    timer_src_next = wb_dat_i[`BIT_SRC_IDX_HI:`BIT_SRC_SEL]; // see RULE12
                end
                default: begin
                    latch_next = latch_reg;
                end
            endcase
        end
        // Recovery from stop mode outranks a simultaneous mode write
        if (stop_mode_recovery)
            mode_next = `RST_PORT_MODE; // see RULE8
    end

    // Sticky flags: a new edge wins over a software clear
    always @* begin
        flag_a_next = edge_a | (flag_a_reg & ~clr_a); // see RULE11
        flag_b_next = edge_b | (flag_b_reg & ~clr_b); // see RULE11
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always @* begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            `OFS_PORT_DATA: begin
                rd_data[7:0] = port_readback; // see RULE13
            end
            `OFS_PORT_MODE: begin
                rd_data[`BIT_DIR_HIGH:`BIT_DIR_LOW] = mode_reg;
            end
            `OFS_PORT_CONFIG: begin
                rd_data[`BIT_OPEN_DRAIN] = open_drain_select_bit_reg;
            end
            `OFS_CMP_MODE: begin
                rd_data[`BIT_CMP_ENABLE] = cmp_enable_reg;
            end
            `OFS_IRQ_REQUEST: begin
                rd_data[`BIT_EDGE_HI:`BIT_EDGE_LO] = edge_mode_reg;
                rd_data[`BIT_FLAG_A]               = flag_a_reg;
                rd_data[`BIT_FLAG_B]               = flag_b_reg;
            end
            `OFS_CMP_STATUS: begin
                rd_data[1:0] = {cmp_value_b, cmp_value_a}; // see RULE9
            end
            `OFS_TIMER_SRC: begin
                rd_data[`BIT_SRC_IDX_HI:`BIT_SRC_SEL] = timer_src_reg;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            latch_reg                 <= `RST_PORT_DATA;
            mode_reg                  <= `RST_PORT_MODE; // see RULE5
            open_drain_select_bit_reg <= `RST_OPEN_DRAIN;
            cmp_enable_reg            <= `RST_CMP_ENABLE;
            edge_mode_reg             <= `RST_EDGE_MODE;
            flag_a_reg                <= 1'b0;
            flag_b_reg                <= 1'b0;
            timer_src_reg             <= `RST_TIMER_SRC;
        end else begin
            latch_reg                 <= latch_next;
            mode_reg                  <= mode_next;
            open_drain_select_bit_reg <= open_drain_select_bit_next;
            cmp_enable_reg            <= cmp_enable_next;
            edge_mode_reg             <= edge_mode_next;
            flag_a_reg                <= flag_a_next;
            flag_b_reg                <= flag_b_next;
            timer_src_reg             <= timer_src_next;
        end
    end

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req)
                wb_dat_o <= rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    // Open-drain lines only pull low; a high latch releases the pin
    always @(posedge clk) begin
        if (rst) begin
            port_out  <= 8'h00;
            port_oe   <= 8'h00; // see RULE5
            pullup_en <= 8'h00;
        end else begin
            port_out  <= latch_next & {8{open_drain_select_bit_next}}; // see RULE1 see RULE3
            port_oe   <= enable_next; // see RULE1 see RULE3
            pullup_en <= pullup_option & ~drive_next; // see RULE7
        end
    end

    // ----------------------------------------------------------------
    // Request and timer outputs
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            irq_request_a <= 1'b0;
            irq_request_b <= 1'b0;
            timer_edge_in <= 1'b0;
        end else begin
            irq_request_a <= flag_a_next;
            irq_request_b <= flag_b_next;
            timer_edge_in <= timer_src_next_level; // see RULE12
        end
    end

endmodule

// *** test/nibble_port_checker.sv ***
/*
 * Port-level assertions for the nibble port.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "nibble_port_regs.vh"

module nibble_port_checker #(
    parameter PULLUP_LOW  = 1'b0,
    parameter PULLUP_HIGH = 1'b0
) (
    input wire        clk,
    input wire        rst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        stop_mode_recovery,
    input wire [7:0]  port_out,
    input wire [7:0]  port_oe,
    input wire [7:0]  pullup_en,
    input wire        irq_request_a,
    input wire        irq_request_b
);
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    wire req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire irq_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `OFS_IRQ_REQUEST;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence smr_held;
        stop_mode_recovery [*2];
    endsequence
    sequence inputs_settled;
        port_oe == 8'h00 && pullup_en == {{4{PULLUP_HIGH[0]}}, {4{PULLUP_LOW[0]}}};
    endsequence

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (req |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_reset_drivers_off: assert property (disable iff (1'b0) rst |=> port_oe == 8'h00 && !wb_ack_o)
        else $error("drivers on after reset");
    a_low_mix_od: assert property (port_oe[3:0] != 4'h0 && port_oe[3:0] != 4'hf |-> port_out[3:0] == 4'h0)
        else $error("mixed low nibble drive not open drain");
    a_high_mix_od: assert property (port_oe[7:4] != 4'h0 && port_oe[7:4] != 4'hf |-> port_out[7:4] == 4'h0)
        else $error("mixed high nibble drive not open drain");
    a_pullup_off_out: assert property ((pullup_en & port_oe) == 8'h00)
        else $error("pull-up on a driven line");
    a_smr_oe_off: assert property (stop_mode_recovery |=> port_oe == 8'h00)
        else $error("drive kept through stop recovery");
    a_smr_pullup_back: assert property (smr_held |=> inputs_settled)
        else $error("pull-ups not restored after stop recovery");
    a_irq_a_sticky: assert property (irq_request_a && !irq_wr |=> irq_request_a)
        else $error("flag a dropped without clear");
    a_irq_b_sticky: assert property (irq_request_b && !irq_wr |=> irq_request_b)
        else $error("flag b dropped without clear");
endmodule

bind nibble_port_with_comparator_inputs nibble_port_checker #(
    .PULLUP_LOW(PULLUP_LOW), .PULLUP_HIGH(PULLUP_HIGH)) checker_i (.clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .stop_mode_recovery, .port_out, .port_oe, .pullup_en,
    .irq_request_a, .irq_request_b);

// *** test/port_board.sv ***
/*
 * Board circuitry on the eight port pins: resolves each pin level.
 * Assumes pins undriven and unpulled float and toggle every cycle.
 */
`timescale 1ns/1ps

module port_board (
    input  wire       clk,
    input  wire [7:0] port_out,
    input  wire [7:0] port_oe,
    input  wire [7:0] pullup_en,
    input  wire [7:0] ext_val,
    input  wire [7:0] ext_en,
    input  wire       board_pullup,
    output reg  [7:0] port_in
);
    reg [7:0] float_reg = 8'h55;
    integer   i;

    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            if (port_oe[i])
                port_in[i] = port_out[i];
            else if (ext_en[i])
                port_in[i] = ext_val[i];
            else if (pullup_en[i] || board_pullup)
                port_in[i] = 1'b1;
            else
                port_in[i] = float_reg[i];
        end
    end
endmodule

// *** test/testbench.sv ***
/*
 * Register-level tests of the nibble port over classic Wishbone.
 * Assumes the board model on the pins and a 25 MHz clock.
 */
`timescale 1ns/1ps
`include "nibble_port_regs.vh"

module testbench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         wb_cyc_i = 1'b0;
    reg         wb_stb_i = 1'b0;
    reg         wb_we_i = 1'b0;
    reg  [7:0]  wb_adr_i = 8'h00;
    reg  [3:0]  wb_sel_i = 4'h0;
    reg  [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o;
    wire [7:0]  port_in;
    wire [7:0]  port_out;
    wire [7:0]  port_oe;
    wire [7:0]  pullup_en;
    reg         stop_mode_recovery = 1'b0;
    reg         comparator_input_a = 1'b0;
    reg         comparator_input_b = 1'b0;
    reg         comparator_result_a = 1'b0;
    reg         comparator_result_b = 1'b0;
    reg  [7:0]  port2_in = 8'h00;
    wire        irq_request_a;
    wire        irq_request_b;
    wire        timer_edge_in;
    reg  [7:0]  ext_val = 8'ha5;
    reg  [7:0]  ext_en = 8'hff;
    reg         board_pullup = 1'b0;
    integer     num_errors = 0;
    integer     checked = 0;
    integer     cycles = 0;
    integer     m;
    reg  [31:0] checked_dummy;

    nibble_port_with_comparator_inputs #(.PULLUP_LOW(1'b1), .PULLUP_HIGH(1'b1))
        nibble_port_with_comparator_inputs_i (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_in, .port_out, .port_oe, .pullup_en,
        .stop_mode_recovery, .comparator_input_a, .comparator_input_b, .comparator_result_a,
        .comparator_result_b, .port2_in, .irq_request_a, .irq_request_b, .timer_edge_in);
    port_board port_board_i (.clk, .port_out, .port_oe, .pullup_en, .ext_val, .ext_en, .board_pullup,
        .port_in);

    // ------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------
    always #20 clk = ~clk;

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end

    task wrap_up;
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task check(input string name, input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wb_cycle(input w, input [7:0] adr, input [3:0] sel, input [31:0] dat, output [31:0] rd);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task wr(input [7:0] adr, input [31:0] dat);
        reg [31:0] unused;
        wb_cycle(1'b1, adr, 4'hf, dat, unused);
    endtask

    task rd_chk(input [7:0] adr, input [31:0] exp, input string name);
        reg [31:0] rd;
        wb_cycle(1'b0, adr, 4'hf, 32'h0, rd);
        check(name, rd, exp);
    endtask

    // ------------------------------------------------
    // Test sequence
    // ------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("port_oe", port_oe, 32'h0);
        check("pullup_en", pullup_en, 32'hff);
        rd_chk(`OFS_PORT_MODE, 32'h3, "mode");
        rd_chk(`OFS_PORT_CONFIG, 32'h0, "config");
        rd_chk(8'h1c, 32'h0, "unmapped");
        rd_chk(`OFS_PORT_DATA, 32'ha5, "pins");
        ext_en <= 8'hf0;
        wr(`OFS_PORT_CONFIG, 32'h4);
        wr(`OFS_PORT_DATA, 32'h3c);
        wr(`OFS_PORT_MODE, 32'h2);
        check("port_oe", port_oe, 32'h0f);
        check("port_out", port_out[3:0], 32'hc);
        check("pullup_en", pullup_en, 32'hf0);
        rd_chk(`OFS_PORT_DATA, 32'hac, "mixed");
        ext_en <= 8'h00;
        wr(`OFS_PORT_MODE, 32'h0);
        check("port_oe", port_oe, 32'hff);
        check("port_out", port_out, 32'h3c);
        board_pullup <= 1'b1;
        wr(`OFS_PORT_CONFIG, 32'h0);
        check("port_oe od", port_oe, 32'hc3);
        check("port_out od", port_out, 32'h0);
        rd_chk(`OFS_PORT_DATA, 32'h3c, "latch");
        wb_cycle(1'b1, `OFS_PORT_MODE, 4'he, 32'h3, checked_dummy);
        rd_chk(`OFS_PORT_MODE, 32'h0, "lane0 off");
        stop_mode_recovery <= 1'b1;
        repeat (2) @(posedge clk);
        stop_mode_recovery <= 1'b0;
        rd_chk(`OFS_PORT_MODE, 32'h3, "mode smr");
        check("port_oe smr", port_oe, 32'h0);
        check("pullup smr", pullup_en, 32'hff);
        rd_chk(`OFS_PORT_DATA, 32'hff, "pulled inputs");
        for (m = 0; m < 4; m = m + 1) begin
            wr(`OFS_IRQ_REQUEST, {m[1:0], 6'h3});
            comparator_input_a <= 1'b1;
            comparator_input_b <= 1'b1;
            repeat (4) @(posedge clk);
            check("irq_a rise", irq_request_a, m != 1);
            check("irq_b rise", irq_request_b, m != 1);
            wr(`OFS_IRQ_REQUEST, {m[1:0], 6'h3});
            check("irq_a clear", irq_request_a, 32'h0);
            check("irq_b clear", irq_request_b, 32'h0);
            comparator_input_a <= 1'b0;
            comparator_input_b <= 1'b0;
            repeat (4) @(posedge clk);
            check("irq_a fall", irq_request_a, m != 0);
            check("irq_b fall", irq_request_b, m != 0);
        end
        wr(`OFS_CMP_MODE, 32'h2);
        wr(`OFS_IRQ_REQUEST, 32'h3);
        comparator_input_a <= 1'b1;
        comparator_input_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("irq_a pin", irq_request_a, 32'h0);
        check("irq_b pin", irq_request_b, 32'h0);
        comparator_result_a <= 1'b1;
        comparator_result_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("irq_a cmp", irq_request_a, 32'h1);
        check("irq_b cmp", irq_request_b, 32'h1);
        rd_chk(`OFS_CMP_STATUS, 32'h3, "status");
        wr(`OFS_TIMER_SRC, 32'h0);
        repeat (4) @(posedge clk);
        check("timer cmp", timer_edge_in, 32'h1);
        port2_in <= 8'h20;
        wr(`OFS_TIMER_SRC, 32'hb);
        repeat (4) @(posedge clk);
        check("timer p2 hi", timer_edge_in, 32'h1);
        port2_in <= 8'hdf;
        repeat (4) @(posedge clk);
        check("timer p2 lo", timer_edge_in, 32'h0);
        wrap_up;
    end
endmodule
